// >>> cif_core.sv
// Purpose: core interrupt control register, flags and combined request
// Assumes: timer overflow and peripheral flags are same-clock pulses;
//          ext_irq_pin and upper_port_pins are asynchronous pins
// Notes:   flag set beats a software clear in the same cycle
// Overview of operation
// - port-change interrupt only requests core_irq while its enable bit is one
// - rising edge on external pin sets its flag; software clears it
// - upper port pins differing from latched value keep setting flag until port read
// - peripheral requests blocked unless peripheral-group enable is set
// - flags set regardless of any enable bit
// - no core_irq request while global enable is zero; irq ignores global enable
`timescale 1ns/10ps
module cif_core
  import cif_pkg::*;
#(
  parameter int PERI_W = 8
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              timer_ovf,
  input  wire logic [PERI_W-1:0] peri_evt,
  input  wire logic              ext_irq_pin,
  input  wire logic [3:0]        upper_port_pins,
  output logic                   core_irq,
  output logic                   irq
);
  cif_bus_t          bus;
  cif_evt_t          evt;
  logic [7:0]        interrupt_control;
  logic [7:0]        next_ctrl;
  logic [PERI_W-1:0] peripheral_enable_reg;
  logic [PERI_W-1:0] next_peri_en;
  logic [PERI_W-1:0] peri_flag;
  logic [PERI_W-1:0] next_peri_flag;
  logic [3:0]        port_latch;
  logic [3:0]        next_port_latch;
  logic [2:0]        irq_stat;
  logic [2:0]        next_irq_stat;
  logic [2:0]        irq_mask;
  logic [2:0]        next_irq_mask;
  logic [7:0]        next_rdata;
  logic              next_core_irq;
  logic              next_irq;
  logic              ext_sync;
  logic              ext_prev;
  logic [3:0]        port_sync;
  logic              mismatch;
  logic              wr_ctrl;
  logic              rd_port;

  // peripheral bits must fit in one register byte
  if (PERI_W < 1 || PERI_W > CIF_DW) begin
    $error("cif_core peripheral width out of range");
  end

  cif_sync #(.WIDTH(1)) u_sync_ext (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (ext_irq_pin),
    .dout    (ext_sync)
  );

  cif_sync #(.WIDTH(4)) u_sync_port (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (upper_port_pins),
    .dout    (port_sync)
  );

  assign bus      = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign mismatch = (port_sync != port_latch);
  assign evt      = '{timer_ovf: timer_ovf, ext_edge: ext_sync & ~ext_prev,
                      port_change: mismatch};
  assign wr_ctrl  = bus.wr && (bus.addr == CIF_ADDR_CTRL);
  assign rd_port  = bus.rd && (bus.addr == CIF_ADDR_PORT);

  // control register and flags
  always_comb begin
    next_ctrl    = interrupt_control;
    next_peri_en = peripheral_enable_reg;
    next_irq_mask = irq_mask;
    if (wr_ctrl) begin
      next_ctrl = bus.wdata;
    end
    if (bus.wr && bus.addr == CIF_ADDR_PERI_EN) begin
      next_peri_en = bus.wdata[PERI_W-1:0];
    end
    if (bus.wr && bus.addr == CIF_ADDR_IRQ_MASK) begin
      next_irq_mask = bus.wdata[2:0];
    end
    // set after write so a same-cycle event is never lost
    if (evt.timer_ovf) begin
      next_ctrl[CIF_BIT_TF] = 1'b1;
    end
    if (evt.ext_edge) begin
      next_ctrl[CIF_BIT_XF] = 1'b1;
    end
    if (evt.port_change) begin
      next_ctrl[CIF_BIT_PCF] = 1'b1;
    end
    next_peri_flag = peri_flag;
    if (bus.wr && bus.addr == CIF_ADDR_PERI_FLG) begin
      next_peri_flag = bus.wdata[PERI_W-1:0];
    end
    next_peri_flag = next_peri_flag | peri_evt;
  end

  // port latch: reading the port ends the mismatch
  always_comb begin
    next_port_latch = port_latch;
    if (rd_port) begin
      next_port_latch = port_sync;
    end
  end

  // sticky status of events, write one to clear, set wins
  always_comb begin
    next_irq_stat = irq_stat;
    if (bus.wr && bus.addr == CIF_ADDR_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~bus.wdata[2:0];
    end
    next_irq_stat = next_irq_stat | {evt.timer_ovf, evt.ext_edge, evt.port_change};
    next_irq = |(irq_stat & irq_mask);
  end

  // combined core request
  always_comb begin
    logic core_src;
    logic peri_src;
    core_src = (interrupt_control[CIF_BIT_TF] & interrupt_control[CIF_BIT_TIE])
             | (interrupt_control[CIF_BIT_XF] & interrupt_control[CIF_BIT_XIE])
             | (interrupt_control[CIF_BIT_PCF]
                & interrupt_control[CIF_BIT_PCIE]);
    peri_src = interrupt_control[CIF_BIT_PERIPHERAL_GROUP_ENABLE]
             & (|(peri_flag & peripheral_enable_reg));
    next_core_irq = interrupt_control[CIF_BIT_GIE] & (core_src | peri_src);
  end

  // read data, one cycle after the strobe, zero otherwise
  always_comb begin
    next_rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        CIF_ADDR_CTRL:     next_rdata = interrupt_control;
        CIF_ADDR_PERI_EN:  next_rdata = 8'(peripheral_enable_reg);
        CIF_ADDR_PERI_FLG: next_rdata = 8'(peri_flag);
        CIF_ADDR_PORT:     next_rdata = {port_sync, 4'h0};
        CIF_ADDR_IRQ_STAT: next_rdata = {5'h00, irq_stat};
        CIF_ADDR_IRQ_MASK: next_rdata = {5'h00, irq_mask};
        default:           next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      interrupt_control     <= CIF_CTRL_RST;
      peripheral_enable_reg <= CIF_PERI_RST[PERI_W-1:0];
      peri_flag             <= CIF_PERI_RST[PERI_W-1:0];
      port_latch            <= 4'h0;
      irq_stat              <= CIF_STAT_RST;
      irq_mask              <= CIF_STAT_RST;
      ext_prev              <= 1'b0;
      reg_rdata             <= 8'h00;
      core_irq              <= 1'b0;
      irq                   <= 1'b0;
    end else begin
      interrupt_control     <= next_ctrl;
      peripheral_enable_reg <= next_peri_en;
      peri_flag             <= next_peri_flag;
      port_latch            <= next_port_latch;
      irq_stat              <= next_irq_stat;
      irq_mask              <= next_irq_mask;
      ext_prev              <= ext_sync;
      reg_rdata             <= next_rdata;
      core_irq              <= next_core_irq;
      irq                   <= next_irq;
    end
  end
endmodule

// >>> cif_core_sva.sv
// Purpose: port checks for the core interrupt flag block
// Assumes: enables and mask are shadowed from register writes
// Notes:   hardware never alters enable bits, so the shadow stays exact
`timescale 1ns/10ps
module cif_core_sva
  import cif_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       timer_ovf,
  input wire logic       core_irq,
  input wire logic       irq
);
  logic [7:3] en;
  logic [2:0] msk;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en  <= 5'h00;
      msk <= 3'h0;
    end else if (reg_wr && reg_addr == CIF_ADDR_CTRL) begin
      en <= reg_wdata[7:3];
    end else if (reg_wr && reg_addr == CIF_ADDR_IRQ_MASK) begin
      msk <= reg_wdata[2:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  gie_off_a: assert property (!$past(en[7]) |-> !core_irq)
    else $error("request while global enable low");
  peri_block_a: assert property ($past(en[6:3]) == 4'h0 |-> !core_irq)
    else $error("request with group and port enables low");
  timer_req_a: assert property (timer_ovf && en[7] && en[5] && !reg_wr ##1 !reg_wr
    |=> core_irq) else $error("timer request missing");
  timer_mask_a: assert property (timer_ovf && msk[2] && !reg_wr ##1 !reg_wr |=> irq)
    else $error("status interrupt missing");
  ctrl_read_a: assert property (reg_rd && reg_addr == CIF_ADDR_CTRL
    |=> reg_rdata[7:3] == $past(en)) else $error("enable bits read back wrong");
  unmapped_a: assert property (reg_rd && reg_addr > CIF_ADDR_IRQ_MASK |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  port_read_a: assert property (reg_rd && reg_addr == CIF_ADDR_PORT
    |=> reg_rdata[3:0] == 4'h0) else $error("port read low nibble not zero");
  cover property (core_irq && en[6]);
  cover property (irq);
  cover property (reg_rd && reg_addr == CIF_ADDR_PORT);
endmodule
bind cif_core cif_core_sva cif_core_sva_i (.clk, .sys_rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .timer_ovf, .core_irq, .irq);

// >>> cif_core_tb.sv
// Purpose: register-level tests of the core interrupt flag block
// Assumes: pins held steady long enough to cross the synchroniser
// Notes:   software clears flags by writes, as the core would
`timescale 1ns/10ps
module cif_core_tb import cif_pkg::*; ;
  logic       clk;
  logic       sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       timer_ovf = 1'b0;
  logic [7:0] peri_evt = 8'h00;
  logic       ext_irq_pin = 1'b0;
  logic [3:0] upper_port_pins = 4'h0;
  logic [7:0] reg_rdata;
  logic [7:0] n_irq;
  logic       core_irq;
  logic       irq;
  int         errors = 0;
  int         n_checks = 0;
  cif_core #(.PERI_W(8)) cif_core_i (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .timer_ovf, .peri_evt, .ext_irq_pin, .upper_port_pins, .core_irq, .irq);
  cif_cpu_model cif_cpu_model_i (.clk, .sys_rst, .core_irq, .n_taken(n_irq));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask
  task ic(input logic e);
    repeat (2) @(posedge clk);
    #1 chk("core_irq", {7'h0, e}, {7'h0, core_irq});
  endtask
  task tick();
    @(posedge clk);
    timer_ovf <= 1'b1;
    @(posedge clk);
    timer_ovf <= 1'b0;
  endtask
  task final_report();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    wr(4'hf, 8'hff);
    for (int i = 0; i < 16; i++) rd(4'(i), 8'h00);
    tick();
    rd(CIF_ADDR_CTRL, 8'h04);
    ic(1'b0);
    rd(CIF_ADDR_CTRL, 8'h04);
    wr(CIF_ADDR_CTRL, 8'ha4);
    ic(1'b1);
    wr(CIF_ADDR_CTRL, 8'h24);
    ic(1'b0);
    wr(CIF_ADDR_CTRL, 8'ha0);
    rd(CIF_ADDR_CTRL, 8'ha0);
    wr(CIF_ADDR_IRQ_MASK, 8'h04);
    tick();
    ic(1'b1);
    chk("irq", 8'h01, {7'h0, irq});
    wr(CIF_ADDR_IRQ_STAT, 8'h07);
    wr(CIF_ADDR_CTRL, 8'h00);
    ic(1'b0);
    chk("irq", 8'h00, {7'h0, irq});
    @(posedge clk);
    ext_irq_pin <= 1'b1;
    repeat (8) @(posedge clk);
    rd(CIF_ADDR_CTRL, 8'h02);
    @(posedge clk);
    ext_irq_pin <= 1'b0;
    rd(CIF_ADDR_CTRL, 8'h02);
    wr(CIF_ADDR_CTRL, 8'h92);
    ic(1'b1);
    wr(CIF_ADDR_CTRL, 8'h00);
    upper_port_pins <= 4'ha;
    repeat (8) @(posedge clk);
    rd(CIF_ADDR_CTRL, 8'h01);
    wr(CIF_ADDR_CTRL, 8'h00);
    rd(CIF_ADDR_CTRL, 8'h01);
    rd(CIF_ADDR_PORT, 8'ha0);
    wr(CIF_ADDR_CTRL, 8'h00);
    rd(CIF_ADDR_CTRL, 8'h00);
    wr(CIF_ADDR_CTRL, 8'h80);
    upper_port_pins <= 4'h5;
    repeat (8) @(posedge clk);
    ic(1'b0);
    wr(CIF_ADDR_CTRL, 8'h89);
    ic(1'b1);
    rd(CIF_ADDR_PORT, 8'h50);
    wr(CIF_ADDR_CTRL, 8'h00);
    wr(CIF_ADDR_PERI_EN, 8'h01);
    peri_evt <= 8'h01;
    @(posedge clk);
    peri_evt <= 8'h00;
    wr(CIF_ADDR_CTRL, 8'h80);
    ic(1'b0);
    wr(CIF_ADDR_CTRL, 8'hc0);
    ic(1'b1);
    rd(CIF_ADDR_PERI_FLG, 8'h01);
    chk("requests taken", 8'h05, n_irq);
    final_report();
  end
endmodule

// >>> cif_cpu_model.sv
// Purpose: core-side model counting accepted interrupt requests
// Assumes: core_irq is a registered level
// Notes:   counts rising edges only, as a core vectors once per request
`timescale 1ns/10ps
module cif_cpu_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       core_irq,
  output logic      [7:0] n_taken
);
  logic seen;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seen    <= 1'b0;
      n_taken <= 8'h00;
    end else begin
      seen <= core_irq;
      if (core_irq && !seen) n_taken <= n_taken + 8'h01;
    end
  end
endmodule

// >>> cif_pkg.sv
// Purpose: constants and types for the core interrupt flag block
// Assumes: one 40 MHz clock, synchronous active-high reset
// Notes:   register map is byte-wide, data in low bits of the read word except the port, read in the upper nibble
package cif_pkg;
  localparam int          CIF_AW            = 4;
  localparam int          CIF_DW            = 8;
  localparam logic [3:0]  CIF_ADDR_CTRL     = 4'h0;
  localparam logic [3:0]  CIF_ADDR_PERI_EN  = 4'h1;
  localparam logic [3:0]  CIF_ADDR_PERI_FLG = 4'h2;
  localparam logic [3:0]  CIF_ADDR_PORT     = 4'h3;
  localparam logic [3:0]  CIF_ADDR_IRQ_STAT = 4'h4;
  localparam logic [3:0]  CIF_ADDR_IRQ_MASK = 4'h5;
  localparam int          CIF_BIT_GIE       = 7;
  localparam int          CIF_BIT_PERIPHERAL_GROUP_ENABLE      = 6;
  localparam int          CIF_BIT_TIE       = 5;
  localparam int          CIF_BIT_XIE       = 4;
  localparam int          CIF_BIT_PCIE      = 3;
  localparam int          CIF_BIT_TF        = 2;
  localparam int          CIF_BIT_XF        = 1;
  localparam int          CIF_BIT_PCF       = 0;
  localparam logic [7:0]  CIF_CTRL_RST      = 8'h00;
  localparam logic [7:0]  CIF_PERI_RST      = 8'h00;
  localparam logic [2:0]  CIF_STAT_RST      = 3'h0;
  localparam int          CIF_SYNC_STAGES   = 3;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cif_bus_t;

  typedef struct packed {
    logic       timer_ovf;
    logic       ext_edge;
    logic       port_change;
  } cif_evt_t;
endpackage

// >>> cif_sync.sv
// Purpose: three-stage synchroniser for pin inputs with agreement filter
// Assumes: input is asynchronous to clk
// Notes:   output changes only when stages two and three agree
`timescale 1ns/10ps
module cif_sync
  import cif_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_dout;

  // refused at elaboration, before any clock runs
  if (WIDTH < 1) begin
    $error("cif_sync width must be at least one");
  end

  // only s2 reads s1
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_dout[i] = (s2[i] == s3[i]) ? s3[i] : dout[i];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      dout <= '0;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= next_dout;
    end
  end
endmodule
